// ==== adc_stats_map.vh ====
// register map and constants for the adc result statistics block
`ifndef ADC_STATS_MAP_VH
`define ADC_STATS_MAP_VH
// ***********************************
// register indices (byte address = 4 x index)
// ***********************************
`define REG_CONV_CTRL      8'h50
`define REG_CONV_CFG       8'h51
`define REG_MEAN_RESULT    8'h53
`define REG_LOWEST_RESULT  8'h54
`define REG_HIGHEST_RESULT 8'h55
// ***********************************
// fields and reset values
// ***********************************
`define GO_BIT             0
`define SIZE_LSB           3
`define SIZE_MSB           5
`define CFG_RESET          8'h00
`define RESULT_RESET       8'h00
`define UNMAPPED_READ      32'h0000_0000
`endif

// ==== adc_stats_accum.v ====
// running sum, lowest and highest tracker for one sample burst
`timescale 1ns/10ps
module adc_stats_accum #(
  parameter DATA_W = 8,
  parameter SUM_W  = 15
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst_n,
  // control
  input  wire              clear,
  input  wire              sample_valid,
  input  wire [DATA_W-1:0] sample_data,
  // running results
  output reg  [SUM_W-1:0]  sum,
  output reg  [DATA_W-1:0] lowest_value,
  output reg  [DATA_W-1:0] highest_value
);

  // clear wins; otherwise fold in each sample
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sum           <= {SUM_W{1'b0}};
      lowest_value  <= {DATA_W{1'b1}};
      highest_value <= {DATA_W{1'b0}};
    end else if (clear) begin
      sum           <= {SUM_W{1'b0}};
      lowest_value  <= {DATA_W{1'b1}};
      highest_value <= {DATA_W{1'b0}};
    end else if (sample_valid) begin
      sum <= sum + {{(SUM_W-DATA_W){1'b0}}, sample_data};
      if (sample_data < lowest_value)
        lowest_value <= sample_data;
      if (sample_data > highest_value)
        highest_value <= sample_data;
    end
  end

endmodule // adc_stats_accum

// ==== adc_result_statistics.v ====
// adc burst control and result statistics with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "adc_stats_map.vh"
module adc_result_statistics #(
  parameter DATA_W = 8
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst_n,
  // avalon-mm slave
  input  wire [9:0]        avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  // converter side
  output reg               sample_request,
  input  wire              sample_valid,
  input  wire [DATA_W-1:0] sample_data,
  output wire              conversion_busy
);

  // ***********************************
  // widths and sequencer states
  // ***********************************
  // the sum must hold 128 full-scale samples without wrapping
  localparam SUM_W   = DATA_W + 7;
  // one-hot states: idle waits for go, run collects, done publishes
  localparam S_IDLE  = 3'b001;
  localparam S_RUN   = 3'b010;
  localparam S_DONE  = 3'b100;

  // ***********************************
  // registers and state
  // ***********************************
  // software-visible fields
  reg               conversion_go;
  reg  [2:0]        burst_size_exponent;
  reg  [DATA_W-1:0] mean_value;
  reg  [DATA_W-1:0] lowest_result;
  reg  [DATA_W-1:0] highest_result;

  // sequencer and bus handshake
  reg  [2:0]        state;
  reg  [7:0]        sample_count;
  reg               access_done;
  wire              last_sample;

  // accumulator outputs and the scaled sum
  wire [SUM_W-1:0]  sum;
  wire [SUM_W-1:0]  sum_scaled;
  wire [DATA_W-1:0] lowest_value;
  wire [DATA_W-1:0] highest_value;

  // access decode
  wire [7:0]        reg_index;
  wire              wr_go;
  wire              wr_cfg;
  wire              rd_start;

  // byte address to register index
  // the bus carries byte addresses; registers sit on word boundaries
  function [7:0] word_index;
    input [9:0] addr;
    begin
      word_index = addr[9:2];
    end
  endfunction

  assign reg_index = word_index(avs_address);

  // index of the final sample in a burst of 2^size_code samples
  function [7:0] burst_last;
    input [2:0] size_code;
    begin
      burst_last = (8'h01 << size_code) - 8'h01;
    end
  endfunction

  // ***********************************
  // bus handshake: one wait cycle per access
  // ***********************************
  // every access takes two cycles: the first raises waitrequest and
  // fetches read data, the second drops it and lets a write land; since
  // access_done falls on the completing edge, a request that follows
  // at once gets its own wait cycle again
  assign avs_waitrequest = (avs_read | avs_write) & ~access_done;

  // marks the completing cycle of each access
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      access_done <= 1'b0;
    else
      access_done <= (avs_read | avs_write) & ~access_done;
  end

  // ***********************************
  // access decode
  // ***********************************
  // writes land only on the completing cycle, so a held request acts once;
  // byte lane 0 must be enabled, as every field sits in the low byte
  assign wr_go = avs_write & access_done & avs_byteenable[0]
                 & (reg_index == `REG_CONV_CTRL) & avs_writedata[`GO_BIT];

  // configuration write strobe
  assign wr_cfg = avs_write & access_done & avs_byteenable[0]
                  & (reg_index == `REG_CONV_CFG);

  // read data is fetched on the first cycle so it stands when the wait drops
  assign rd_start = avs_read & ~access_done;

  // configuration register write; the result registers have no write path
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      burst_size_exponent <= 3'b000;
    else if (wr_cfg)
      burst_size_exponent <= avs_writedata[`SIZE_MSB:`SIZE_LSB];
  end

  // read data captured on the first cycle, standing at the completing edge
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= `UNMAPPED_READ;
    end else if (rd_start) begin
      // only the low byte carries data; upper bits read zero
      case (reg_index)
        `REG_CONV_CTRL:      avs_readdata <= {31'h0000_0000, conversion_go};
        `REG_CONV_CFG:       avs_readdata <= {26'h000_0000, burst_size_exponent, 3'b000};
        `REG_MEAN_RESULT:    avs_readdata <= {24'h00_0000, mean_value};
        `REG_LOWEST_RESULT:  avs_readdata <= {24'h00_0000, lowest_result};
        `REG_HIGHEST_RESULT: avs_readdata <= {24'h00_0000, highest_result};
        default:             avs_readdata <= `UNMAPPED_READ;
      endcase
    end
  end

  // ***********************************
  // burst sequencer
  // ***********************************
  // busy only while samples are still being collected
  assign conversion_busy = state[1];

  // final sample of the selected burst length
  assign last_sample = sample_valid
                       & (sample_count == burst_last(burst_size_exponent));

  // the burst length is a power of two, so a right shift gives the floor of the mean
  assign sum_scaled = sum >> burst_size_exponent;

  // start on go, count 2^N samples, publish, clear go
  // a go write while collecting or publishing is dropped; go still reads one
  // the size setting should be left alone while busy: it sets the length
  // and the divisor, and both are read again at the end of the burst
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state          <= S_IDLE;
      conversion_go  <= 1'b0;
      sample_count   <= 8'h00;
      sample_request <= 1'b0;
      mean_value     <= `RESULT_RESET;
      lowest_result  <= `RESULT_RESET;
      highest_result <= `RESULT_RESET;
    end else begin
      case (state)
        // idle: wait for software to write go
        S_IDLE: begin
          sample_request <= 1'b0;
          if (wr_go) begin
            conversion_go  <= 1'b1;
            sample_count   <= 8'h00;
            sample_request <= 1'b1;
            state          <= S_RUN;
          end
        end
        // run: request samples until the burst is full
        S_RUN: begin
          // each accepted sample advances the count
          if (sample_valid) begin
            if (last_sample) begin
              sample_request <= 1'b0;
              state          <= S_DONE;
            end
            sample_count <= sample_count + 8'h01;
          end
        end
        // done: publish the results and release go
        S_DONE: begin
          // the last sample is already folded into the sum by now
          mean_value     <= sum_scaled[DATA_W-1:0];
          lowest_result  <= lowest_value;
          highest_result <= highest_value;
          conversion_go  <= 1'b0;
          state          <= S_IDLE;
        end
        // an illegal code falls back to idle
        default: state <= S_IDLE;
      endcase
    end
  end

  // ***********************************
  // accumulator
  // ***********************************
  // the trackers restart on an accepted go, so each burst reports only its
  // own samples; strobes outside a burst are masked by the run state
  adc_stats_accum #(
    .DATA_W (DATA_W),
    .SUM_W  (SUM_W)
  ) u_accum (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .clear         (wr_go & state[0]),
    .sample_valid  (sample_valid & state[1]),
    .sample_data   (sample_data),
    .sum           (sum),
    .lowest_value  (lowest_value),
    .highest_value (highest_value)
  );

endmodule // adc_result_statistics

// ==== adc_result_statistics_properties.sv ====
// bus and burst timing checks for the adc result statistics block
`timescale 1ns/10ps
module adc_result_statistics_properties (
  // watched ports
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        sample_request,
  input wire logic        conversion_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire req = avs_read | avs_write;
  wire rd_done = avs_read & !avs_waitrequest;
  // one wait cycle, then completion
  chk_one_wait: assert property (req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait cycle count wrong");
  chk_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 0)
    else $error("read data upper bits set");
  chk_unmapped_zero: assert property (rd_done && avs_address[9:2] < 8'h50 |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  chk_data_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  chk_go_starts: assert property (avs_write && !avs_waitrequest && avs_address == 10'h140
    && avs_writedata[0] && avs_byteenable[0] && !conversion_busy |=> sample_request && conversion_busy)
    else $error("go did not start burst");
  chk_req_in_burst: assert property (sample_request |-> conversion_busy)
    else $error("sample request outside burst");
  // main scenarios
  cover property (rd_done);
  cover property ($rose(conversion_busy));
  cover property ($fell(conversion_busy));
endmodule // adc_result_statistics_properties
bind adc_result_statistics adc_result_statistics_properties chk (.*);

// ==== adc_result_statistics_tb.sv ====
// self-checking bench for the adc result statistics block
`timescale 1ns/10ps
module adc_result_statistics_tb;
  logic        clk_sys = 0;
  logic        rst_n = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic        sample_valid = 0;
  logic [9:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [7:0]  sample_data = 0;
  logic [31:0] rdata;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         sample_request;
  wire         conversion_busy;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          e_mean, e_lo, e_hi;
  adc_result_statistics DUT (.*);
  always #10 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest low
  task automatic acc(input logic [9:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdata = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    acc(a, 0, 0);
    chk(rdata, e);
  endtask
  // launch a burst of 2^n samples and check the results
  task automatic burst(input int n, input int b);
    int s, v;
    s = 0;
    e_lo = 255;
    e_hi = 0;
    acc(10'h144, 1, n << 3);
    rd(10'h144, n << 3);
    acc(10'h140, 1, 1);
    chk({30'h0, sample_request, conversion_busy}, 32'h0000_0003);
    for (int k = 0; k < (1 << n); k++) begin
      v = (k * 37 + b) & 255;
      s += v;
      e_lo = (v < e_lo) ? v : e_lo;
      e_hi = (v > e_hi) ? v : e_hi;
      sample_data <= v[7:0];
      sample_valid <= 1;
      @(posedge clk_sys);
      sample_valid <= 0;
      @(posedge clk_sys);
    end
    e_mean = s >> n;
    rdata = 1;
    repeat (8) if (rdata[0] !== 1'b0) acc(10'h140, 0, 0);
    chk(rdata, 0);
    chk({30'h0, sample_request, conversion_busy}, 32'h0000_0000);
    rd(10'h14c, e_mean);
    rd(10'h150, e_lo);
    rd(10'h154, e_hi);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(10'h14c, 0);
    for (int n = 7; n >= 0; n--) burst(n, n * 11 + 3);
    acc(10'h14c, 1, 32'h0000_00aa);
    acc(10'h150, 1, 32'h0000_00aa);
    rd(10'h14c, e_mean);
    rd(10'h150, e_lo);
    rd(10'h000, 0);
    stop_test();
  end
endmodule // adc_result_statistics_tb
